// ### shared/wel_guard_pkg.sv
// constants and types for the write-enable latch and register write guard
package latch_guard_pkg;

   // =====================================================================
   // instruction codes
   localparam logic [7:0] OP_SET_LATCH       = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH       = 8'h04;
   localparam logic [7:0] OP_CLR_FAIL        = 8'h82;
   localparam logic [7:0] OP_CLR_FAIL_LEGACY = 8'h30;
   localparam logic [7:0] OP_REG_WRITE       = 8'h01;
   localparam logic [7:0] OP_PAGE_PROG       = 8'h02;
   localparam logic [7:0] OP_SECT_ERASE      = 8'hd8;
   localparam logic [7:0] OP_BULK_ERASE      = 8'h60;

   // =====================================================================
   // frame bit counts
   localparam int unsigned BIT_CNT_W = 13;
   localparam logic [BIT_CNT_W-1:0] BITS_OPCODE   = 13'h0008;
   localparam logic [BIT_CNT_W-1:0] BITS_REG_ONE  = 13'h0010;
   localparam logic [BIT_CNT_W-1:0] BITS_REG_TWO  = 13'h0018;
   localparam logic [BIT_CNT_W-1:0] BITS_SECT     = 13'h0020;
   localparam logic [BIT_CNT_W-1:0] BITS_PROG_MIN = 13'h0028;
   localparam logic [BIT_CNT_W-1:0] BITS_SAT      = 13'h1fff;
   localparam logic [BIT_CNT_W-1:0] BITS_SERIAL   = 13'h0001;
   localparam logic [BIT_CNT_W-1:0] BITS_QUAD     = 13'h0004;

   // =====================================================================
   // register layouts and reset values
   typedef struct packed {
      logic       reg_write_disable_bit;
      logic       p_err;
      logic       e_err;
      logic [2:0] bp;
      logic       write_enable_latch;
      logic       write_in_progress;
   } status_t;

   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam int unsigned CFG_QE_BIT  = 1;
   localparam int unsigned WP_IO_LINE  = 2;

   typedef struct packed {
      logic       cs_n;
      logic       sclk;
      logic [3:0] io;
   } spi_pins_t;

   localparam logic [5:0] PINS_IDLE = 6'h20;

   typedef enum logic [1:0] {ARR_PROG, ARR_SECT, ARR_BULK} array_cmd_t;
   typedef enum {WR_IDLE, WR_BUSY} rw_state_t;

   // =====================================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS     = 100;
   localparam int unsigned REG_WRITE_TIME_NS = 2000;
   localparam int unsigned REG_WRITE_CYCLES  =
      (REG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] REG_WRITE_LAST = 8'(REG_WRITE_CYCLES - 1);

endpackage

// ### design/write_enable_and_register_guard.sv
// write-enable latch, fail flags and register write guard of a serial flash
`timescale 1ns/10ps
// =====================================================================
module write_enable_and_register_guard
   import latch_guard_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire spi_pins_t  pins_i,
   input  wire logic       four_line_mode_i,
   input  wire logic       legacy_resume_sel_i,
   input  wire logic       target_protected_i,
   input  wire logic       array_busy_i,
   input  wire logic       program_fail_i,
   input  wire logic       erase_fail_i,
   output status_t         status_o,
   output logic [7:0]      config_o,
   output logic            hw_locked_o,
   output logic            array_go_o,
   output array_cmd_t      array_cmd_o
);

   // =====================================================================
   // pin synchronisers
   spi_pins_t pin_s1_q;
   spi_pins_t pin_s2_q;
   logic      sclk_s3_q;
   logic      cs_s3_q;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_s1_q  <= spi_pins_t'(PINS_IDLE);
         pin_s2_q  <= spi_pins_t'(PINS_IDLE);
         sclk_s3_q <= 1'b0;
         cs_s3_q   <= 1'b1;
      end else begin
         pin_s1_q  <= pins_i;
         pin_s2_q  <= pin_s1_q;
         sclk_s3_q <= pin_s2_q.sclk;
         cs_s3_q   <= pin_s2_q.cs_n;
      end
   end

   logic sclk_rise;
   logic frame_start;
   logic frame_end;
   assign sclk_rise   = pin_s2_q.sclk & ~sclk_s3_q & ~pin_s2_q.cs_n;
   assign frame_start = ~pin_s2_q.cs_n & cs_s3_q;
   assign frame_end   = pin_s2_q.cs_n & ~cs_s3_q;

   // =====================================================================
   // instruction shifter
   logic [23:0]          shift_q;
   logic [23:0]          shift_d;
   logic [BIT_CNT_W-1:0] cnt_q;
   logic [BIT_CNT_W-1:0] cnt_d;
   logic [BIT_CNT_W-1:0] step;
   logic [7:0]           op_q;

   always_comb begin
      step    = four_line_mode_i ? BITS_QUAD : BITS_SERIAL;
      shift_d = shift_q;
      cnt_d   = cnt_q;
      if (frame_start) begin
         cnt_d = '0;
      end else if (sclk_rise) begin
         // four bits per clock in four-line mode
         if (four_line_mode_i) begin
            shift_d = {shift_q[19:0], pin_s2_q.io};
         end else begin
            shift_d = {shift_q[22:0], pin_s2_q.io[0]};
         end
         if (cnt_q > BITS_SAT - step) begin
            cnt_d = BITS_SAT;
         end else begin
            cnt_d = cnt_q + step;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_q <= '0;
         cnt_q   <= '0;
         op_q    <= '0;
      end else begin
         shift_q <= shift_d;
         cnt_q   <= cnt_d;
         if (cnt_q < BITS_OPCODE && cnt_d == BITS_OPCODE) begin
            op_q <= shift_d[7:0];
         end
      end
   end

   // =====================================================================
   // state registers
   logic       latch_q;
   logic       wr_disable_q;
   logic [2:0] bp_q;
   logic       perr_q;
   logic       eerr_q;
   logic       in_prog_q;
   logic [7:0] cfg_q;
   logic       hw_lock_q;
   rw_state_t  rw_state_q;
   logic [7:0] timer_q;
   logic [7:0] pend_sr_q;
   logic [7:0] pend_cfg_q;
   logic       pend_cfg_en_q;
   logic       array_go_q;
   array_cmd_t array_cmd_q;

   // =====================================================================
   // frame decode
   logic       set_latch;
   logic       clr_latch;
   logic       clr_fail;
   logic       reg_wr;
   logic       arr_go;
   logic       arr_ok;
   logic       wr_done;
   array_cmd_t arr_cmd;

   // array commands need the latch and an idle device
   assign arr_ok  = latch_q & ~in_prog_q;
   assign wr_done = (rw_state_q == WR_BUSY) && (timer_q == 8'h00);

   always_comb begin
      set_latch = 1'b0;
      clr_latch = 1'b0;
      clr_fail  = 1'b0;
      reg_wr    = 1'b0;
      arr_go    = 1'b0;
      arr_cmd   = ARR_PROG;
      if (frame_end) begin
         case (op_q)
            // set latch only when frame ends at bit eight
            OP_SET_LATCH: set_latch = (cnt_q == BITS_OPCODE);
            // clear latch at bit eight when idle
            OP_CLR_LATCH: clr_latch = (cnt_q == BITS_OPCODE) && !in_prog_q;
            // clear flags regardless of latch or busy
            OP_CLR_FAIL: clr_fail = (cnt_q == BITS_OPCODE);
            OP_CLR_FAIL_LEGACY: clr_fail = (cnt_q == BITS_OPCODE) && !legacy_resume_sel_i;
            OP_REG_WRITE: reg_wr = (cnt_q == BITS_REG_ONE || cnt_q == BITS_REG_TWO)
                                   && latch_q && !in_prog_q && !hw_lock_q;
            OP_PAGE_PROG: begin
               arr_go = (cnt_q >= BITS_PROG_MIN) && (cnt_q[2:0] == 3'h0) && arr_ok && !target_protected_i;
            end
            OP_SECT_ERASE: begin
               arr_cmd = ARR_SECT;
               arr_go  = (cnt_q == BITS_SECT) && arr_ok && !target_protected_i;
            end
            OP_BULK_ERASE: begin
               arr_cmd = ARR_BULK;
               arr_go  = (cnt_q == BITS_OPCODE) && arr_ok && (bp_q == 3'h0);
            end
            default: ;
         endcase
      end
   end

   // =====================================================================
   // hardware protection
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         hw_lock_q <= 1'b0;
      end else begin
         // lock follows bit and pin levels, quad mode frees it
         hw_lock_q <= wr_disable_q & ~pin_s2_q.io[WP_IO_LINE] & ~cfg_q[CFG_QE_BIT];
      end
   end

   // =====================================================================
   // write-enable latch
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         latch_q <= STATUS_RESET[1];
      end else if (set_latch) begin
         latch_q <= 1'b1;
      end else if (clr_latch || wr_done) begin
         latch_q <= 1'b0;
      end
   end

   // =====================================================================
   // fail flags and busy
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         perr_q    <= STATUS_RESET[6];
         eerr_q    <= STATUS_RESET[5];
         in_prog_q <= STATUS_RESET[0];
      end else begin
         // flags clear, a new failure wins
         perr_q    <= program_fail_i | (perr_q & ~clr_fail);
         eerr_q    <= erase_fail_i | (eerr_q & ~clr_fail);
         // busy during write, array work or fail flags
         in_prog_q <= (rw_state_q == WR_BUSY) | array_busy_i | perr_q | eerr_q;
      end
   end

   // =====================================================================
   // self-timed register write
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rw_state_q    <= WR_IDLE;
         timer_q       <= '0;
         pend_sr_q     <= '0;
         pend_cfg_q    <= '0;
         pend_cfg_en_q <= 1'b0;
         wr_disable_q  <= STATUS_RESET[7];
         bp_q          <= STATUS_RESET[4:2];
         cfg_q         <= CONFIG_RESET;
      end else begin
         case (rw_state_q)
            WR_IDLE: begin
               if (reg_wr) begin
                  rw_state_q    <= WR_BUSY;
                  timer_q       <= REG_WRITE_LAST;
                  pend_cfg_en_q <= (cnt_q == BITS_REG_TWO);
                  pend_sr_q     <= (cnt_q == BITS_REG_TWO) ? shift_q[15:8] : shift_q[7:0];
                  pend_cfg_q    <= shift_q[7:0];
               end
            end
            WR_BUSY: begin
               if (timer_q == 8'h00) begin
                  rw_state_q   <= WR_IDLE;
                  wr_disable_q <= pend_sr_q[7];
                  bp_q         <= pend_sr_q[4:2];
                  if (pend_cfg_en_q) begin
                     cfg_q <= pend_cfg_q;
                  end
               end else begin
                  timer_q <= timer_q - 8'h01;
               end
            end
            default: rw_state_q <= WR_IDLE;
         endcase
      end
   end

   // =====================================================================
   // array command launch
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         array_go_q  <= 1'b0;
         array_cmd_q <= ARR_PROG;
      end else begin
         array_go_q <= arr_go;
         if (arr_go) begin
            array_cmd_q <= arr_cmd;
         end
      end
   end

   // =====================================================================
   // outputs
   // all fields reset to zero
   assign status_o    = '{reg_write_disable_bit: wr_disable_q, p_err: perr_q, e_err: eerr_q, bp: bp_q,
                          write_enable_latch: latch_q, write_in_progress: in_prog_q};
   assign config_o    = cfg_q;
   assign hw_locked_o = hw_lock_q;
   assign array_go_o  = array_go_q;
   assign array_cmd_o = array_cmd_q;

   // =====================================================================
   // checks
   a_latch_set_ok: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && op_q == OP_SET_LATCH && cnt_q == BITS_OPCODE |=> latch_q)
      else $error("latch not set by set command");
   a_latch_set_count: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && op_q == OP_SET_LATCH && cnt_q != BITS_OPCODE && rw_state_q == WR_IDLE |=> $stable(latch_q))
      else $error("latch changed by misframed set command");
   a_latch_clr_ok: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && op_q == OP_CLR_LATCH && cnt_q == BITS_OPCODE && !in_prog_q |=> !latch_q)
      else $error("latch not cleared by clear command");
   a_latch_clr_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && op_q == OP_CLR_LATCH && in_prog_q && rw_state_q == WR_IDLE |=> $stable(latch_q))
      else $error("clear command acted while busy");
   a_fail_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && op_q == OP_CLR_FAIL && cnt_q == BITS_OPCODE && !program_fail_i && !erase_fail_i
      |=> !perr_q && !eerr_q)
      else $error("fail flags not cleared");
   a_fail_keep_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && op_q == OP_CLR_FAIL && rw_state_q == WR_IDLE |=> $stable(latch_q))
      else $error("clear-status changed the latch");
   a_lock_reject: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && op_q == OP_REG_WRITE && hw_lock_q && rw_state_q == WR_IDLE |=> rw_state_q == WR_IDLE)
      else $error("register write accepted under lock");
   a_write_accept: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && op_q == OP_REG_WRITE && cnt_q == BITS_REG_ONE && latch_q && !in_prog_q && !hw_lock_q
      |=> rw_state_q == WR_BUSY ##1 in_prog_q)
      else $error("register write not started");
   a_write_end: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_done && !set_latch |=> !latch_q && rw_state_q == WR_IDLE)
      else $error("latch kept after register write");
   a_quad_unlock: assert property (@(posedge mclk_i) disable iff (rst_i)
      cfg_q[CFG_QE_BIT] && $stable(cfg_q) |=> !hw_lock_q)
      else $error("lock active in quad mode");
   a_region_guard: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_end && target_protected_i && (op_q == OP_PAGE_PROG || op_q == OP_SECT_ERASE) |=> !array_go_q)
      else $error("protected region accepted program or erase");

endmodule // write_enable_and_register_guard

// ### sim/spi_host_model.sv
// host-side serial flash controller model that drives the pin bundle
`timescale 1ns/10ps
module spi_host_model
   import latch_guard_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic wp_n_i,
   output spi_pins_t pins_o
);
   logic       cs_n_q = 1'b1;
   logic       sclk_q = 1'b0;
   logic [3:0] io_q   = 4'h0;
   logic       quad_q = 1'b0;

   // line 2 carries the protect level unless a four-line frame owns it
   assign pins_o = '{cs_n: cs_n_q, sclk: sclk_q, io: {io_q[3], quad_q ? io_q[2] : wp_n_i, io_q[1:0]}};

   // =====================================================================
   // frame transfer, link clock 800 ns, parked low between frames
   task automatic send(input logic [39:0] val, input int nbits, input logic quad);
      int units;
      units = quad ? nbits / 4 : nbits;
      @(posedge mclk_i);
      quad_q <= quad;
      cs_n_q <= 1'b0;
      for (int i = 0; i < units; i++) begin
         @(posedge mclk_i);
         // msb first, one nibble or one bit per rising clock
         io_q   <= quad ? val[nbits-1-4*i -: 4] : {io_q[3:1], val[nbits-1-i]};
         sclk_q <= 1'b0;
         repeat (4) @(posedge mclk_i);
         sclk_q <= 1'b1;
         repeat (3) @(posedge mclk_i);
      end
      @(posedge mclk_i);
      sclk_q <= 1'b0;
      repeat (3) @(posedge mclk_i);
      // chip select raised three clocks after the clock line returns low
      cs_n_q <= 1'b1;
      repeat (8) @(posedge mclk_i);
      // released lines show the inverse of the last value
      io_q   <= ~io_q;
      quad_q <= 1'b0;
   endtask
endmodule // spi_host_model

// ### sim/tb.sv
// self-checking bench for the write-enable latch and register guard
`timescale 1ns/10ps
module tb
   import latch_guard_pkg::*;
;
   logic       mclk         = 1'b0;
   logic       rst          = 1'b1;
   logic       wp_n         = 1'b1;
   logic       four_line    = 1'b0;
   logic       legacy_sel   = 1'b0;
   logic       tgt_prot     = 1'b0;
   logic       busy         = 1'b0;
   logic       pfail        = 1'b0;
   logic       efail        = 1'b0;
   int         error_cnt    = 0;
   int         total_checks = 0;
   logic [7:0] go_cnt       = 8'h00;
   spi_pins_t  pins;
   status_t    status;
   logic [7:0] cfg;
   logic       locked;
   logic       go;
   array_cmd_t cmd;

   write_enable_and_register_guard i_dut (
      .mclk_i(mclk), .rst_i(rst), .pins_i(pins), .four_line_mode_i(four_line),
      .legacy_resume_sel_i(legacy_sel), .target_protected_i(tgt_prot), .array_busy_i(busy),
      .program_fail_i(pfail), .erase_fail_i(efail), .status_o(status), .config_o(cfg),
      .hw_locked_o(locked), .array_go_o(go), .array_cmd_o(cmd)
   );

   spi_host_model i_host (.mclk_i(mclk), .wp_n_i(wp_n), .pins_o(pins));

   // =====================================================================
   // clock, pulse counter, helpers
   initial begin
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (go === 1'b1) go_cnt <= go_cnt + 8'h01;
   end

   task automatic chk(input logic [7:0] act, input logic [7:0] exp);
      total_checks++;
      if (act !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, act, exp);
      end
   endtask

   task automatic frm(input logic [39:0] val, input int nbits);
      i_host.send(val, nbits, four_line);
      @(negedge mclk);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic give_verdict();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      give_verdict();
   end

   // =====================================================================
   // test sequence
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      idle(5);
      chk(status, 8'h00);
      chk(cfg, 8'h00);
      frm(40'h06, 8);
      chk(status, 8'h02);
      @(posedge mclk) wp_n <= 1'b0;
      frm(40'h019c, 16);
      chk({7'h0, status.write_in_progress}, 8'h01);
      idle(30);
      chk(status, 8'h9c);
      chk({7'h0, locked}, 8'h01);
      @(posedge mclk) wp_n <= 1'b1;
      idle(6);
      chk({7'h0, locked}, 8'h00);
      frm(40'h06, 8);
      frm(40'h018000, 24);
      idle(30);
      chk(status, 8'h80);
      @(posedge mclk) wp_n <= 1'b0;
      idle(6);
      chk({7'h0, locked}, 8'h01);
      frm(40'h06, 8);
      frm(40'h0100, 16);
      idle(30);
      chk(status, 8'h82);
      // array commands, protected target first
      @(posedge mclk) tgt_prot <= 1'b1;
      frm(40'h0200000000, 40);
      chk(go_cnt, 8'h00);
      @(posedge mclk) tgt_prot <= 1'b0;
      frm(40'h0200000000, 40);
      chk(go_cnt, 8'h01);
      chk(8'(cmd), 8'(ARR_PROG));
      frm(40'hd8000000, 32);
      chk(8'(cmd), 8'(ARR_SECT));
      frm(40'h60, 8);
      chk(8'(cmd), 8'(ARR_BULK));
      chk(go_cnt, 8'h03);
      // quad enable overrides the protect pin
      @(posedge mclk) wp_n <= 1'b1;
      frm(40'h06, 8);
      frm(40'h018002, 24);
      idle(30);
      chk(cfg, 8'h02);
      @(posedge mclk) wp_n <= 1'b0;
      idle(6);
      chk({7'h0, locked}, 8'h00);
      frm(40'h06, 8);
      frm(40'h010000, 24);
      idle(30);
      chk(status, 8'h00);
      chk(cfg, 8'h00);
      @(posedge mclk) wp_n <= 1'b1;
      // latch handling and framing
      frm(40'h06, 8);
      frm(40'h04, 8);
      chk(status, 8'h00);
      frm(40'h019c, 16);
      frm(40'h0200000000, 40);
      idle(30);
      chk(status, 8'h00);
      chk(go_cnt, 8'h03);
      frm(40'h06, 7);
      frm(40'h0c, 9);
      chk(status, 8'h00);
      frm(40'h06, 8);
      frm(40'h08, 9);
      chk(status, 8'h02);
      @(posedge mclk) busy <= 1'b1;
      frm(40'h04, 8);
      chk(status, 8'h03);
      @(posedge mclk) busy <= 1'b0;
      // fail flags and both clear codes
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk);
         pfail      <= (k == 0);
         efail      <= (k != 0);
         legacy_sel <= (k == 2);
         @(posedge mclk);
         pfail <= 1'b0;
         efail <= 1'b0;
         idle(3);
         chk(status, k == 0 ? 8'h43 : 8'h23);
         frm(k == 0 ? 40'h82 : 40'h30, 8);
         chk(status, k == 2 ? 8'h23 : 8'h02);
      end
      frm(40'h82, 8);
      chk(status, 8'h02);
      // four-line command mode
      @(posedge mclk) four_line <= 1'b1;
      idle(2);
      frm(40'h04, 8);
      chk(status, 8'h00);
      frm(40'h06, 8);
      chk(status, 8'h02);
      give_verdict();
   end
endmodule // tb
